// ---- core/scp_config_regs.sv ----
// serial register port with configuration and per-channel power mode registers
`timescale 1ns/1ns

// Operation
// - soft reset bits reset everything, self clear
// - bit order bit selects LSB or MSB first
// - multibyte transfers auto-increment the address
// - single instruction bit allows one transfer
// - datapath reset bit pulses, self clears
// - mode 00 is normal, power-up value
// - mode 10 gates datapath clocks only
// - mode 11 gates, resets, disables link, outputs
module scp_config_regs #(
  parameter int NUM_CHAN = scp_pkg::NUM_CHAN
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic serial_select_n,
  input wire logic sdioIn,
  output logic sdioOut,
  output logic sdioOe,
  input wire logic [NUM_CHAN-1:0] channelSelect,
  output logic softResetPulse,
  output logic datapathResetPulse,
  output logic [NUM_CHAN-1:0] dpClockEnable,
  output logic [NUM_CHAN-1:0] dpHoldReset,
  output logic [NUM_CHAN-1:0] linkEnable,
  output logic [NUM_CHAN-1:0] outputEnable
);

  typedef struct packed {
    logic sclkMeta;
    logic sclkSync;
    logic sclkPrev;
    logic csMeta;
    logic csSync;
    logic sdioMeta;
    logic sdioSync;
    scp_pkg::scp_phase_type phase;
    logic [4:0] bitCnt;
    logic [15:0] instr;
    logic [14:0] addr;
    logic rw;
    logic [7:0] shiftIn;
    logic [7:0] shiftOut;
    logic sdioOut;
    logic sdioOe;
    logic lsbFirst;
    logic addrAscend;
    logic singleInstr;
    logic [2*NUM_CHAN-1:0] modes;
    logic softReset;
    logic dpReset;
  } scp_regs_type;

  localparam scp_regs_type RESET_STATE = '{
    csMeta: 1'b1,
    csSync: 1'b1,
    phase: scp_pkg::PH_IDLE,
    lsbFirst: scp_pkg::RST_CFG_A[scp_pkg::CFGA_LSB_LO],
    addrAscend: scp_pkg::RST_CFG_A[scp_pkg::CFGA_ASC_LO],
    singleInstr: scp_pkg::RST_CFG_B[scp_pkg::CFGB_SINGLE],
    modes: {NUM_CHAN{scp_pkg::RST_POWER[1:0]}},
    default: '0
  };

  scp_regs_type state_reg;
  scp_regs_type state_next;

  // ==========================================================
  // helpers
  // lowest selected channel answers a read, as with several selected
  function automatic logic [1:0] pickMode(input logic [2*NUM_CHAN-1:0] modes,
                                          input logic [NUM_CHAN-1:0] sel);
    logic [1:0] m;
    m = 2'h0;
    for (int i = NUM_CHAN - 1; i >= 0; i--) begin
      if (sel[i]) begin
        m = modes[2*i +: 2];
      end
    end
    return m;
  endfunction

  // read view; reserved and self-clearing bits read zero
  function automatic logic [7:0] readValue(input scp_regs_type s, input logic [14:0] a,
                                           input logic [NUM_CHAN-1:0] sel);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      scp_pkg::OFF_CFG_A: begin
        v[scp_pkg::CFGA_LSB_HI] = s.lsbFirst;
        v[scp_pkg::CFGA_LSB_LO] = s.lsbFirst;
        v[scp_pkg::CFGA_ASC_HI] = s.addrAscend;
        v[scp_pkg::CFGA_ASC_LO] = s.addrAscend;
      end
      scp_pkg::OFF_CFG_B: begin
        v[scp_pkg::CFGB_SINGLE] = s.singleInstr;
      end
      scp_pkg::OFF_POWER: begin
        v[scp_pkg::POWER_MODE_LO +: 2] = pickMode(s.modes, sel);
      end
      default: begin
        v = 8'h00;
      end
    endcase
    return v;
  endfunction

  logic sclkRise;
  logic sclkFall;
  logic [15:0] instrShifted;
  logic [7:0] byteShifted;
  logic [14:0] addrInc;
  logic [7:0] readNow;

  // edges only from synchronised stages, never the first flop
  assign sclkRise = state_reg.sclkSync & ~state_reg.sclkPrev;
  assign sclkFall = ~state_reg.sclkSync & state_reg.sclkPrev;
  // both orders fill the same layout {rw, address} and {d7..d0}
  assign instrShifted = state_reg.lsbFirst ? {state_reg.sdioSync, state_reg.instr[15:1]} :
                        {state_reg.instr[14:0], state_reg.sdioSync};
  assign byteShifted = state_reg.lsbFirst ? {state_reg.sdioSync, state_reg.shiftIn[7:1]} :
                       {state_reg.shiftIn[6:0], state_reg.sdioSync};
  // both settings of the ascension field count upward
  assign addrInc = state_reg.addr + 15'h0001;
  assign readNow = readValue(state_reg, state_reg.addr, channelSelect);

  // ==========================================================
  // frame engine and register writes
  always_comb begin
    state_next = state_reg;
    state_next.softReset = 1'b0;
    state_next.dpReset = 1'b0;
    state_next.sclkMeta = sclk;
    state_next.sclkSync = state_reg.sclkMeta;
    state_next.sclkPrev = state_reg.sclkSync;
    state_next.csMeta = serial_select_n;
    state_next.csSync = state_reg.csMeta;
    state_next.sdioMeta = sdioIn;
    state_next.sdioSync = state_reg.sdioMeta;
    if (state_reg.softReset) begin
      // registers and port restart; rest of the frame is discarded
      state_next = RESET_STATE;
      state_next.sclkMeta = sclk;
      state_next.sclkSync = state_reg.sclkMeta;
      state_next.sclkPrev = state_reg.sclkSync;
      state_next.csMeta = serial_select_n;
      state_next.csSync = state_reg.csMeta;
      state_next.sdioMeta = sdioIn;
      state_next.sdioSync = state_reg.sdioMeta;
      state_next.phase = scp_pkg::PH_HOLD;
    end else if (state_reg.csSync) begin
      state_next.phase = scp_pkg::PH_IDLE;
      state_next.bitCnt = 5'h00;
      state_next.sdioOe = 1'b0;
    end else begin
      case (state_reg.phase)
        scp_pkg::PH_IDLE: begin
          state_next.phase = scp_pkg::PH_INSTR;
          state_next.bitCnt = 5'h00;
        end
        scp_pkg::PH_INSTR: begin
          if (sclkRise) begin
            state_next.instr = instrShifted;
            state_next.bitCnt = state_reg.bitCnt + 5'h01;
            if (state_reg.bitCnt == 5'(scp_pkg::INSTR_BITS - 1)) begin
              state_next.bitCnt = 5'h00;
              state_next.phase = scp_pkg::PH_DATA;
              state_next.rw = instrShifted[15];
              state_next.addr = instrShifted[14:0];
              if (instrShifted[15]) begin
                state_next.shiftOut = readValue(state_reg, instrShifted[14:0], channelSelect);
                state_next.sdioOut = state_reg.lsbFirst ? state_next.shiftOut[0] :
                                     state_next.shiftOut[7];
                state_next.sdioOe = 1'b1;
              end
            end
          end
        end
        scp_pkg::PH_DATA: begin
          if (sclkRise) begin
            state_next.shiftIn = byteShifted;
            state_next.bitCnt = state_reg.bitCnt + 5'h01;
            if (state_reg.bitCnt == 5'(scp_pkg::BYTE_BITS - 1)) begin
              state_next.bitCnt = 5'h00;
              state_next.addr = addrInc;
              if (!state_reg.rw) begin
                // unmapped addresses fall through and are ignored
                case (state_reg.addr)
                  scp_pkg::OFF_CFG_A: begin
                    if (byteShifted[scp_pkg::CFGA_RESET_HI] ||
                        byteShifted[scp_pkg::CFGA_RESET_LO]) begin
                      state_next.softReset = 1'b1;
                    end else begin
                      state_next.lsbFirst = byteShifted[scp_pkg::CFGA_LSB_HI] |
                                            byteShifted[scp_pkg::CFGA_LSB_LO];
                      state_next.addrAscend = byteShifted[scp_pkg::CFGA_ASC_HI] |
                                              byteShifted[scp_pkg::CFGA_ASC_LO];
                    end
                  end
                  scp_pkg::OFF_CFG_B: begin
                    state_next.singleInstr = byteShifted[scp_pkg::CFGB_SINGLE];
                    state_next.dpReset = byteShifted[scp_pkg::CFGB_DP_RESET];
                  end
                  scp_pkg::OFF_POWER: begin
                    for (int i = 0; i < NUM_CHAN; i++) begin
                      if (channelSelect[i]) begin
                        state_next.modes[2*i +: 2] = byteShifted[scp_pkg::POWER_MODE_LO +: 2];
                      end
                    end
                  end
                  default: begin
                    state_next.dpReset = 1'b0;
                  end
                endcase
              end
              if (state_reg.singleInstr) begin
                state_next.phase = scp_pkg::PH_HOLD;
                state_next.sdioOe = 1'b0;
              end else if (state_reg.rw) begin
                state_next.shiftOut = readValue(state_reg, addrInc, channelSelect);
                state_next.sdioOut = state_reg.lsbFirst ? state_next.shiftOut[0] :
                                     state_next.shiftOut[7];
              end
            end
          end else if (sclkFall && state_reg.rw && state_reg.bitCnt != 5'h00) begin
            // falling edge moves the next bit out ahead of the host's sample
            state_next.shiftOut = state_reg.lsbFirst ? {1'b0, state_reg.shiftOut[7:1]} :
                                  {state_reg.shiftOut[6:0], 1'b0};
            state_next.sdioOut = state_reg.lsbFirst ? state_reg.shiftOut[1] :
                                 state_reg.shiftOut[6];
          end
        end
        scp_pkg::PH_HOLD: begin
          state_next.sdioOe = 1'b0;
        end
        default: begin
          state_next.phase = scp_pkg::PH_IDLE;
        end
      endcase
    end
  end

  // single state register for the port and configuration; channel controls are registered in scp_chan_power
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= RESET_STATE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sdioOut = state_reg.sdioOut;
  assign sdioOe = state_reg.sdioOe;
  assign softResetPulse = state_reg.softReset;
  assign datapathResetPulse = state_reg.dpReset;

  // ==========================================================
  // per-channel power controls
  for (genvar g = 0; g < NUM_CHAN; g++) begin : gChan
    scp_chan_power #(
      .MODE_W(scp_pkg::MODE_W)
    ) uPower (
      .mclk(mclk),
      .rst_b(rst_b),
      .powerMode(state_reg.modes[2*g +: 2]),
      .dpSoftReset(state_reg.dpReset),
      .clockEnable(dpClockEnable[g]),
      .holdReset(dpHoldReset[g]),
      .linkEnable(linkEnable[g]),
      .outputEnable(outputEnable[g])
    );
  end

  // ==========================================================
  // checks
  chk_softreset_clears: assert property (@(posedge mclk) disable iff (!rst_b)
    softResetPulse |=> (!state_reg.lsbFirst && !state_reg.addrAscend &&
      !state_reg.singleInstr && state_reg.modes == '0 && !softResetPulse && !sdioOe))
    else $error("soft reset left state behind");
  chk_bit_order: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(sdioOe) |-> (sdioOut == (state_reg.lsbFirst ? state_reg.shiftOut[0] :
      state_reg.shiftOut[7])))
    else $error("first read bit in wrong order");
  chk_addr_increment: assert property (@(posedge mclk) disable iff (!rst_b)
    (state_reg.phase == scp_pkg::PH_DATA && sclkRise && state_reg.bitCnt == 5'h07 &&
      !state_reg.csSync && !state_reg.softReset) |=>
      (state_reg.addr == $past(state_reg.addr) + 15'h0001))
    else $error("address did not increment");
  chk_single_stop: assert property (@(posedge mclk) disable iff (!rst_b)
    (state_reg.phase == scp_pkg::PH_DATA && sclkRise && state_reg.bitCnt == 5'h07 &&
      state_reg.singleInstr && !state_reg.csSync && !state_reg.softReset) |=>
      (state_reg.phase == scp_pkg::PH_HOLD && !sdioOe))
    else $error("single instruction frame kept streaming");
  chk_dp_reset_pulse: assert property (@(posedge mclk) disable iff (!rst_b)
    datapathResetPulse |=> (!datapathResetPulse && dpHoldReset == '1))
    else $error("datapath reset not a single self-clearing pulse");
  chk_reserved_zero: assert property (@(posedge mclk) disable iff (!rst_b)
    (state_reg.addr == scp_pkg::OFF_CFG_A) |->
      (readNow[4:3] == 2'b00 && readNow[7] == 1'b0 && readNow[0] == 1'b0))
    else $error("reserved bit reads nonzero");
  chk_mirror_equal: assert property (@(posedge mclk) disable iff (!rst_b)
    (state_reg.addr == scp_pkg::OFF_CFG_A) |->
      (readNow[6] == readNow[1] && readNow[5] == readNow[2]))
    else $error("mirrored fields disagree");
  chk_cs_releases: assert property (@(posedge mclk) disable iff (!rst_b)
    state_reg.csSync |=> (!sdioOe && state_reg.phase == scp_pkg::PH_IDLE) or
      $past(state_reg.softReset))
    else $error("port not released with chip select high");

endmodule

// ---- core/scp_pkg.sv ----
// constants and types shared by the serial configuration and power mode block
package scp_pkg;

  // ==========================================================
  // serial frame layout
  localparam int ADDR_W = 15;
  localparam int INSTR_BITS = 16;
  localparam int BYTE_BITS = 8;
  localparam int NUM_CHAN = 4;
  localparam int MODE_W = 2;

  // ==========================================================
  // register offsets
  localparam logic [14:0] OFF_CFG_A = 15'h0000;
  localparam logic [14:0] OFF_CFG_B = 15'h0001;
  localparam logic [14:0] OFF_POWER = 15'h0002;

  // ==========================================================
  // field positions
  localparam int CFGA_RESET_HI = 7;
  localparam int CFGA_LSB_HI = 6;
  localparam int CFGA_ASC_HI = 5;
  localparam int CFGA_ASC_LO = 2;
  localparam int CFGA_LSB_LO = 1;
  localparam int CFGA_RESET_LO = 0;
  localparam int CFGB_SINGLE = 7;
  localparam int CFGB_DP_RESET = 1;
  localparam int POWER_MODE_LO = 0;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_CFG_A = 8'h00;
  localparam logic [7:0] RST_CFG_B = 8'h00;
  localparam logic [7:0] RST_POWER = 8'h00;

  // ==========================================================
  // power mode codes
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_STANDBY = 2'h2;
  localparam logic [1:0] MODE_POWERDOWN = 2'h3;

  // ==========================================================
  // host recovery time after a soft reset, kept for reference by software
  localparam int BOOT_WAIT_MS = 5;
  localparam int CLK_MHZ = 50;
  localparam int BOOT_WAIT_CYCLES = BOOT_WAIT_MS * CLK_MHZ * 1000;

  // ==========================================================
  // serial frame phases
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_INSTR = 2'b01,
    PH_DATA = 2'b10,
    PH_HOLD = 2'b11
  } scp_phase_type;

endpackage

// ---- core/scp_chan_power.sv ----
// per-channel decode of the power mode into datapath and link controls
`timescale 1ns/1ns

module scp_chan_power #(
  parameter int MODE_W = 2
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [MODE_W-1:0] powerMode,
  input wire logic dpSoftReset,
  output logic clockEnable,
  output logic holdReset,
  output logic linkEnable,
  output logic outputEnable
);

  typedef struct packed {
    logic clkEn;
    logic hold;
    logic link;
    logic outEn;
  } scp_chan_type;

  scp_chan_type state_reg;
  scp_chan_type state_next;

  // ==========================================================
  // mode decode; code 01 is undocumented and treated as normal
  always_comb begin
    state_next = '{clkEn: 1'b1, hold: dpSoftReset, link: 1'b1, outEn: 1'b1};
    case (powerMode)
      scp_pkg::MODE_STANDBY: begin
        state_next.clkEn = 1'b0;
      end
      scp_pkg::MODE_POWERDOWN: begin
        state_next = '{clkEn: 1'b0, hold: 1'b1, link: 1'b0, outEn: 1'b0};
      end
      default: begin
        state_next.clkEn = 1'b1;
      end
    endcase
  end

  // registered so the controls leave the block glitch free
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= '{clkEn: 1'b1, hold: 1'b0, link: 1'b1, outEn: 1'b1};
    end else begin
      state_reg <= state_next;
    end
  end

  assign clockEnable = state_reg.clkEn;
  assign holdReset = state_reg.hold;
  assign linkEnable = state_reg.link;
  assign outputEnable = state_reg.outEn;

  // ==========================================================
  // checks
  chk_normal_mode: assert property (@(posedge mclk) disable iff (!rst_b)
    (powerMode == scp_pkg::MODE_NORMAL && !dpSoftReset) |=>
      (clockEnable && !holdReset && linkEnable && outputEnable))
    else $error("normal mode does not run the channel");
  chk_standby_mode: assert property (@(posedge mclk) disable iff (!rst_b)
    (powerMode == scp_pkg::MODE_STANDBY) |=> (!clockEnable && linkEnable && outputEnable))
    else $error("standby mode controls wrong");
  chk_powerdown_mode: assert property (@(posedge mclk) disable iff (!rst_b)
    (powerMode == scp_pkg::MODE_POWERDOWN) |=>
      (!clockEnable && holdReset && !linkEnable && !outputEnable))
    else $error("power-down mode controls wrong");

endmodule

// ---- verif/scp_host_model.sv ----
// serial host model that drives the three-wire register port of the block
`timescale 1ns/1ns

module scp_host_model (
  input wire logic mclk,
  output logic sclk,
  output logic serial_select_n,
  output logic sdioIn,
  input wire logic sdioOut,
  input wire logic sdioOe
);
  // ==========================================================
  // pin state
  int halfCyc = 6;
  int bootWait = 200;
  logic lsbFirst = 1'b0;
  logic hostOe = 1'b0;
  logic hostBit = 1'b0;
  logic lastPin = 1'b0;

  // no pull resistor: a released pin shows the inverse of its last level
  assign sdioIn = sdioOe ? sdioOut : (hostOe ? hostBit : ~lastPin);

  // last pin level, for the released case
  always @(posedge mclk) begin
    lastPin <= sdioIn;
  end

  // serial clock idles low, frame select idles high
  initial begin
    sclk = 1'b0;
    serial_select_n = 1'b1;
  end

  // move just after an edge so the block never sees a change on its edge
  task automatic waitCyc(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask

  // one frame: instruction word, then one or two data bytes
  task automatic xfer(input logic rw, input logic [14:0] addr, input logic two,
                      input logic [15:0] wd, output logic [15:0] rd);
    logic [15:0] instr;
    logic [15:0] dataV;
    logic [15:0] rdV;
    int n;
    int idx;
    int j;
    instr = {rw, addr};
    dataV = two ? wd : {wd[7:0], 8'h00};
    rdV = 16'h0000;
    n = two ? 32 : 24;
    rd = 16'h0000;
    // unmapped places are never written
    if (!rw && addr > 15'h0002) begin
      return;
    end
    waitCyc(1);
    serial_select_n = 1'b0;
    hostOe = 1'b1;
    waitCyc(3);
    for (int k = 0; k < n; k++) begin
      // lsb first reverses the instruction word and each byte on its own
      if (k < 16) begin
        idx = lsbFirst ? k : 15 - k;
        hostBit = instr[idx];
      end else begin
        j = (k - 16) % 8;
        idx = 15 - 8 * ((k - 16) / 8) - (lsbFirst ? 7 - j : j);
        hostBit = dataV[idx];
      end
      waitCyc(halfCyc);
      if (k >= 16) begin
        rdV[idx] = sdioIn;
      end
      sclk = 1'b1;
      // keep the last instruction bit one clock past the edge, then turn the pin around
      if (k == 15 && rw) begin
        waitCyc(1);
        hostOe = 1'b0;
        waitCyc(halfCyc - 1);
      end else begin
        waitCyc(halfCyc);
      end
      sclk = 1'b0;
    end
    waitCyc(halfCyc);
    serial_select_n = 1'b1;
    hostOe = 1'b0;
    waitCyc(8);
    rd = two ? rdV : {8'h00, rdV[15:8]};
    // new bit order takes hold once the frame has closed
    if (!rw && addr == 15'h0000) begin
      lsbFirst = dataV[14] | dataV[9];
    end
    // hold off while the device reboots; wait shortened to keep the run short
    if (!rw && addr == 15'h0000 && (dataV[15] | dataV[8])) begin
      lsbFirst = 1'b0;
      waitCyc(bootWait);
    end
  endtask
endmodule

// ---- verif/testbench.sv ----
// self-checking bench for the serial configuration and power mode registers
`timescale 1ns/1ns

module testbench;
  logic mclk;
  logic rst_b;
  logic sclk;
  logic serial_select_n;
  logic sdioIn;
  logic sdioOut;
  logic sdioOe;
  logic [3:0] channelSelect;
  logic softResetPulse;
  logic datapathResetPulse;
  logic [3:0] dpClockEnable;
  logic [3:0] dpHoldReset;
  logic [3:0] linkEnable;
  logic [3:0] outputEnable;
  int fails = 0;
  int nCompared = 0;
  int srCnt = 0;
  int dpCnt = 0;
  logic [15:0] r16;

  scp_config_regs scp_config_regs_i (
    .mclk(mclk), .rst_b(rst_b), .sclk(sclk), .serial_select_n(serial_select_n),
    .sdioIn(sdioIn), .sdioOut(sdioOut), .sdioOe(sdioOe), .channelSelect(channelSelect),
    .softResetPulse(softResetPulse), .datapathResetPulse(datapathResetPulse),
    .dpClockEnable(dpClockEnable), .dpHoldReset(dpHoldReset), .linkEnable(linkEnable),
    .outputEnable(outputEnable)
  );

  scp_host_model scp_host_model_i (
    .mclk(mclk), .sclk(sclk), .serial_select_n(serial_select_n), .sdioIn(sdioIn),
    .sdioOut(sdioOut), .sdioOe(sdioOe)
  );

  // ==========================================================
  // clock and pulse counters
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // counting cycles high also catches a pulse that is too wide
  always @(posedge mclk) begin
    if (softResetPulse === 1'b1) srCnt++;
    if (datapathResetPulse === 1'b1) dpCnt++;
  end

  // ==========================================================
  // shared helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    nCompared++;
    if (got !== exp) begin
      fails++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    scp_host_model_i.xfer(1'b0, a, 1'b0, {8'h00, d}, r16);
  endtask

  task automatic wr2(input logic [14:0] a, input logic [15:0] d);
    scp_host_model_i.xfer(1'b0, a, 1'b1, d, r16);
  endtask

  task automatic rdChk(input logic [14:0] a, input logic [7:0] exp);
    scp_host_model_i.xfer(1'b1, a, 1'b0, 16'h0000, r16);
    chk(r16[7:0], exp);
    chk({7'h00, sdioOe}, 8'h00);
  endtask

  task automatic outs(input logic [3:0] ce, input logic [3:0] hr, input logic [3:0] le,
                      input logic [3:0] oe);
    chk({4'h0, dpClockEnable}, {4'h0, ce});
    chk({4'h0, dpHoldReset}, {4'h0, hr});
    chk({4'h0, linkEnable}, {4'h0, le});
    chk({4'h0, outputEnable}, {4'h0, oe});
  endtask

  task automatic summarize;
    $display("Compared %0d, mismatches %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic testReset;
    rdChk(scp_pkg::OFF_CFG_A, 8'h00);
    rdChk(scp_pkg::OFF_CFG_B, 8'h00);
    rdChk(scp_pkg::OFF_POWER, 8'h00);
    rdChk(15'h0005, 8'h00);
    outs(4'hF, 4'h0, 4'hF, 4'hF);
  endtask

  // slow host; reserved bits written as ones must read back zero
  task automatic testModes;
    logic [1:0] code;
    scp_host_model_i.halfCyc = 14;
    channelSelect = 4'h5;
    for (int i = 0; i < 3; i++) begin
      code = i == 0 ? scp_pkg::MODE_STANDBY : (i == 1 ? scp_pkg::MODE_POWERDOWN : 2'h0);
      wr(scp_pkg::OFF_POWER, {6'h3F, code});
      rdChk(scp_pkg::OFF_POWER, {6'h00, code});
      if (i == 0) outs(4'hA, 4'h0, 4'hF, 4'hF);
      else if (i == 1) outs(4'hA, 4'h5, 4'hA, 4'hA);
      else outs(4'hF, 4'h0, 4'hF, 4'hF);
    end
    scp_host_model_i.halfCyc = 6;
  endtask

  task automatic testStream;
    wr2(scp_pkg::OFF_CFG_B, 16'h0002);
    rdChk(scp_pkg::OFF_POWER, 8'h02);
    wr(scp_pkg::OFF_CFG_B, 8'h80);
    rdChk(scp_pkg::OFF_CFG_B, 8'h80);
    wr2(scp_pkg::OFF_CFG_B, 16'h8003);
    rdChk(scp_pkg::OFF_POWER, 8'h02);
    wr(scp_pkg::OFF_CFG_B, 8'h00);
    wr(scp_pkg::OFF_POWER, 8'h00);
  endtask

  task automatic testDpReset;
    dpCnt = 0;
    wr(scp_pkg::OFF_CFG_B, 8'h7F);
    rdChk(scp_pkg::OFF_CFG_B, 8'h00);
    chk(dpCnt[7:0], 8'h01);
  endtask

  task automatic testLsb;
    wr(scp_pkg::OFF_CFG_A, 8'h24);
    rdChk(scp_pkg::OFF_CFG_A, 8'h24);
    wr(scp_pkg::OFF_CFG_A, 8'h40);
    rdChk(scp_pkg::OFF_CFG_A, 8'h42);
    wr2(scp_pkg::OFF_CFG_B, 16'h0003);
    rdChk(scp_pkg::OFF_POWER, 8'h03);
    outs(4'hA, 4'h5, 4'hA, 4'hA);
  endtask

  // first pass starts in lsb-first order, second in msb-first order
  task automatic testSoftReset;
    logic [7:0] code;
    for (int i = 0; i < 2; i++) begin
      code = i == 0 ? 8'h80 : 8'h01;
      wr(scp_pkg::OFF_POWER, 8'h03);
      srCnt = 0;
      wr(scp_pkg::OFF_CFG_A, code);
      chk(srCnt[7:0], 8'h01);
      rdChk(scp_pkg::OFF_CFG_A, 8'h00);
      rdChk(scp_pkg::OFF_POWER, 8'h00);
      outs(4'hF, 4'h0, 4'hF, 4'hF);
    end
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    rst_b = 1'b0;
    channelSelect = 4'h0;
    repeat (16) @(posedge mclk);
    #2;
    rst_b = 1'b1;
    repeat (4) @(posedge mclk);
    #2;
    testReset();
    testModes();
    testStream();
    testDpReset();
    testLsb();
    testSoftReset();
    summarize();
  end

  // about four and a half times the expected run length
  initial begin
    repeat (60000) @(posedge mclk);
    fails++;
    summarize();
  end
endmodule
